// ---- mcx_regs.svh ----
// Purpose: constants of the mcx instruction execution core
// Assumes: opcode layout below is the core's own encoding
// Notes: cycle counts are core clock cycles
// Summary of operation
// RULE_01: add/and/compare/subtract use accumulator plus memory or immediate; 4 cycles; Z,C updated
// RULE_02: clear, decrement, increment reach all 256 data-space bytes
// RULE_03: complement, rotate-through-carry, shift-left act on accumulator; Z,C updated
// RULE_04: decrement/increment set Z from result, keep C, take 4 cycles
// RULE_05: short branches on C, no C, Z, no Z; one byte, 2 cycles, flags kept
// RULE_06: short displacement is 5-bit signed, reach -15 to +16
// RULE_07: bit-test branches: three bytes, 5 cycles, on bit clear/set, reach -126..+129
// RULE_08: bit-test branch copies tested bit into C, keeps Z
// RULE_09: bit set/clear reach any data-space bit by 3-bit index; 4 cycles; no flags
// RULE_10: jump and call load a 12-bit target; two bytes, 4 cycles, flags kept
// RULE_11: nop, return, interrupt return, stop, wait: 2 cycles; only interrupt return alters flags
// RULE_12: with watchdog selected, stop is executed as wait
// RULE_13: pointer and short-direct registers live at data-space 80h to 83h
`ifndef MCX_REGS_SVH
`define MCX_REGS_SVH
`define MCX_ADDR_X 8'h80
`define MCX_ADDR_ACC 8'hff
`define MCX_PTR_HI 6'h20
`define MCX_PC_RST 12'h000
`define MCX_STACK_DEPTH 3'd6
`define MCX_CYC_SHORT 3'd2
`define MCX_CYC_LONG 3'd4
`define MCX_CYC_BTB 3'd5
`define MCX_NIB_CALL 4'h1
`define MCX_NIB_JP 4'h9
`define MCX_NIB_BTB 4'h3
`define MCX_NIB_BSC 4'hb
`define MCX_NIB_SD 4'h5
`define MCX_NIB_IND 4'h7
`define MCX_NIB_DIR 4'hf
`define MCX_NIB_INH 4'hd
`define MCX_INH_NOP 4'h0
`define MCX_INH_RET 4'h1
`define MCX_INH_INTERRUPT_RETURN_OP 4'h2
`define MCX_INH_STOP 4'h3
`define MCX_INH_WAIT 4'h4
`define MCX_INH_COM 4'h5
`define MCX_INH_RLC 4'h6
`define MCX_INH_SLA 4'h7
`endif

// ---- mcx_pkg.sv ----
// Purpose: types of the mcx instruction execution core
// Assumes: nothing
// Notes: encodings are binary and fixed
package mcx_pkg;
    typedef enum logic [3:0] {
        F_ADD = 4'h0, F_AND = 4'h1, F_CP = 4'h2, F_SUB = 4'h3,
        F_INC = 4'h4, F_DEC = 4'h5, F_CLR = 4'h6, F_COM = 4'h7,
        F_RLC = 4'h8, F_SLA = 4'h9, F_BSET = 4'ha, F_BCLR = 4'hb,
        F_NONE = 4'hc
    } mcx_func_type;
    typedef enum logic [3:0] {
        C_REL = 4'h0, C_JP = 4'h1, C_CALL = 4'h2, C_BTB = 4'h3, C_BSC = 4'h4,
        C_SD = 4'h5, C_IND = 4'h6, C_DIR = 4'h7, C_IMM = 4'h8, C_INH = 4'h9
    } mcx_class_type;
    typedef enum logic [1:0] {
        S_RUN = 2'b00, S_WAIT = 2'b01, S_STOP = 2'b10
    } mcx_state_type;
endpackage : mcx_pkg

// ---- mcx_alu.sv ----
// Purpose: arithmetic and bit unit of the mcx core
// Assumes: carry on subtract and compare means borrow
// Notes: purely combinational
`timescale 1ns/100ps
module mcx_alu import mcx_pkg::*; (
    // operation
    input wire mcx_func_type func,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    input wire logic cin,
    // result
    output logic [7:0] res,
    output logic z,
    output logic c,
    output logic upd_z,
    output logic upd_c,
    output logic wr
);
    always_comb begin
        logic [8:0] w;
        w = {1'b0, a};
        res = a;
        c = cin;
        upd_z = 1'b1;
        upd_c = 1'b1;
        wr = 1'b1;
        case (func)
            F_ADD: begin
                w = {1'b0, a} + {1'b0, b};
                {c, res} = w;
            end
            F_AND: begin
                res = a & b;
                c = 1'b0;
            end
            F_CP, F_SUB: begin
                w = {1'b0, a} - {1'b0, b};
                {c, res} = w;
                wr = (func == F_SUB);
            end
            F_INC: begin
                res = a + 8'h01;
                upd_c = 1'b0;
            end
            F_DEC: begin
                res = a - 8'h01;
                upd_c = 1'b0;
            end
            F_CLR: begin
                res = 8'h00;
                c = 1'b0;
            end
            F_COM: begin
                res = ~a;
                c = a[7];
            end
            F_RLC: {c, res} = {a, cin};
            F_SLA: {c, res} = {a, 1'b0};
            F_BSET, F_BCLR: begin
                res = (func == F_BSET) ? (a | (8'h01 << bit_sel)) : (a & ~(8'h01 << bit_sel));
                upd_z = 1'b0;
                upd_c = 1'b0;
            end
            default: begin
                wr = 1'b0;
                upd_z = 1'b0;
                upd_c = 1'b0;
            end
        endcase
        z = (res == 8'h00);
    end
endmodule : mcx_alu

// ---- mcx_reltgt.sv ----
// Purpose: relative branch targets of the mcx core
// Assumes: ipc is the address of the branch opcode
// Notes: short form uses sign bit op[3] and span op[7:4]
`timescale 1ns/100ps
module mcx_reltgt (
    // instruction
    input wire logic [11:0] ipc,
    input wire logic [7:0] op,
    input wire logic [7:0] disp,
    // targets
    output logic [11:0] short_tgt,
    output logic [11:0] bt_tgt
);
    // forward spans 1..16, backward 0..15
    assign short_tgt = op[3] ? (ipc - {8'h00, op[7:4]}) : (ipc + {8'h00, op[7:4]} + 12'h001);
    // bias of two gives -126..+129
    assign bt_tgt = ipc + 12'h002 + {{4{disp[7]}}, disp};
endmodule : mcx_reltgt

// ---- mcx_core.sv ----
// Purpose: instruction execution of the mcx 8-bit core
// Assumes: prog_data and dmem_rdata answer the registered address in the same cycle
// Notes: load/store opcodes are not decoded here
`timescale 1ns/100ps
`include "mcx_regs.svh"
module mcx_core import mcx_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program space
    output logic [11:0] prog_addr_ff,
    input wire logic [7:0] prog_data,
    // data space
    output logic [7:0] dmem_addr_ff,
    output logic dmem_we_ff,
    output logic [7:0] dmem_wdata_ff,
    input wire logic [7:0] dmem_rdata,
    // interrupt and power control
    input wire logic irq_req,
    input wire logic [11:0] irq_vector,
    input wire logic wake,
    input wire logic watchdog_sel,
    // status
    output logic zero_ff,
    output logic carry_ff,
    output logic [7:0] acc_ff,
    output logic in_isr_ff,
    output logic wait_ff,
    output logic stop_ff,
    output logic done_ff
);
    function automatic mcx_class_type class_of(input logic [7:0] op);
        case (op[3:0])
            `MCX_NIB_CALL: class_of = C_CALL;
            `MCX_NIB_JP: class_of = C_JP;
            `MCX_NIB_BTB: class_of = C_BTB;
            `MCX_NIB_BSC: class_of = C_BSC;
            `MCX_NIB_SD: class_of = C_SD;
            `MCX_NIB_IND: class_of = C_IND;
            `MCX_NIB_DIR: class_of = op[4] ? C_IMM : C_DIR;
            `MCX_NIB_INH: class_of = C_INH;
            default: class_of = C_REL;
        endcase
    endfunction : class_of

    function automatic mcx_func_type func_of(input logic [7:0] op);
        func_of = F_NONE;
        case (class_of(op))
            C_DIR, C_IND, C_IMM: begin
                case (op[7:5])
                    3'h0: func_of = F_ADD;
                    3'h1: func_of = F_AND;
                    3'h2: func_of = F_CP;
                    3'h3: func_of = F_SUB;
                    3'h4: func_of = F_INC;
                    3'h5: func_of = F_DEC;
                    3'h6: func_of = F_CLR;
                    default: func_of = F_NONE;
                endcase
                // no memory target behind an immediate
                if (class_of(op) == C_IMM && op[7]) func_of = F_NONE;
            end
            C_SD: func_of = op[5] ? F_NONE : (op[4] ? F_DEC : F_INC);
            C_BSC: func_of = op[4] ? F_BSET : F_BCLR;
            C_INH: begin
                case (op[7:4])
                    `MCX_INH_COM: func_of = F_COM;
                    `MCX_INH_RLC: func_of = F_RLC;
                    `MCX_INH_SLA: func_of = F_SLA;
                    default: func_of = F_NONE;
                endcase
            end
            default: func_of = F_NONE;
        endcase
    endfunction : func_of

    function automatic logic [2:0] cycles_of(input mcx_class_type cls);
        case (cls)
            C_REL, C_INH: cycles_of = `MCX_CYC_SHORT; // RULE_05 RULE_11
            C_BTB: cycles_of = `MCX_CYC_BTB; // RULE_07
            default: cycles_of = `MCX_CYC_LONG; // RULE_01 RULE_04 RULE_09 RULE_10
        endcase
    endfunction : cycles_of

    function automatic logic is_ptr(input logic [7:0] addr);
        is_ptr = (addr[7:2] == `MCX_PTR_HI);
    endfunction : is_ptr

    function automatic logic rel_taken(input logic [7:0] op, input logic z, input logic c);
        case (op[2:1])
            2'b00: rel_taken = !z;
            2'b01: rel_taken = !c;
            2'b10: rel_taken = z;
            2'b11: rel_taken = c;
            default: rel_taken = 1'b0;
        endcase
    endfunction : rel_taken

    // sequencing state
    mcx_state_type state_ff, nxt_state;
    logic [2:0] cyc_ff, nxt_cyc;
    logic [7:0] op_ff, nxt_op;
    logic [11:0] ipc_ff, nxt_ipc;
    logic [7:0] opnd_ff, nxt_opnd;
    logic [7:0] disp_ff, nxt_disp;
    logic [11:0] nxt_pc;
    logic [7:0] nxt_daddr, nxt_wdata, nxt_acc;
    logic nxt_we, nxt_z, nxt_c, nxt_isr, nxt_done;
    logic sav_z_ff, sav_c_ff, nxt_sav_z, nxt_sav_c;
    // x, y, v, w held inside the core
    logic [7:0] ptr_ff [0:3];
    logic [7:0] nxt_ptr [0:3];
    logic [11:0] stk_ff [0:5];
    logic [11:0] nxt_stk [0:5];
    logic [2:0] sp_ff, nxt_sp;

    logic [7:0] op_cur, rd_val, alu_a, alu_res, waddr;
    mcx_class_type cls_cur, cls_ex;
    mcx_func_type func_ex;
    logic last, irq_take, start, acc_dest, alu_z, alu_c, upd_z, upd_c, alu_wr, tbit;
    logic [11:0] short_tgt, bt_tgt;

    assign op_cur = (cyc_ff == 3'd0) ? prog_data : op_ff;
    assign cls_cur = class_of(op_cur);
    assign cls_ex = class_of(op_ff);
    assign func_ex = func_of(op_ff);
    assign last = (cyc_ff == cycles_of(cls_cur) - 3'd1);
    assign irq_take = (state_ff == S_RUN) && (cyc_ff == 3'd0) && irq_req && !in_isr_ff;
    assign start = (state_ff == S_RUN) && (cyc_ff == 3'd0) && !irq_take;
    assign rd_val = (dmem_addr_ff == `MCX_ADDR_ACC) ? acc_ff :
                    is_ptr(dmem_addr_ff) ? ptr_ff[dmem_addr_ff[1:0]] : dmem_rdata; // RULE_13
    assign acc_dest = func_ex inside {F_ADD, F_AND, F_CP, F_SUB, F_COM, F_RLC, F_SLA};
    assign alu_a = acc_dest ? acc_ff : opnd_ff;
    assign waddr = acc_dest ? `MCX_ADDR_ACC : dmem_addr_ff;
    assign tbit = opnd_ff[op_ff[7:5]];

    mcx_alu u_alu (
        .func(func_ex),
        .a(alu_a),
        .b(opnd_ff),
        .bit_sel(op_ff[7:5]),
        .cin(carry_ff),
        .res(alu_res),
        .z(alu_z),
        .c(alu_c),
        .upd_z(upd_z),
        .upd_c(upd_c),
        .wr(alu_wr)
    );

    mcx_reltgt u_reltgt (
        .ipc(ipc_ff),
        .op(op_ff),
        .disp(disp_ff),
        .short_tgt(short_tgt),
        .bt_tgt(bt_tgt)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_cyc = cyc_ff;
        nxt_op = op_ff;
        nxt_ipc = ipc_ff;
        nxt_opnd = opnd_ff;
        nxt_disp = disp_ff;
        nxt_pc = prog_addr_ff;
        nxt_daddr = dmem_addr_ff;
        nxt_we = 1'b0;
        nxt_wdata = dmem_wdata_ff;
        nxt_acc = acc_ff;
        nxt_z = zero_ff;
        nxt_c = carry_ff;
        nxt_isr = in_isr_ff;
        nxt_sav_z = sav_z_ff;
        nxt_sav_c = sav_c_ff;
        nxt_done = 1'b0;
        nxt_ptr = ptr_ff;
        nxt_stk = stk_ff;
        nxt_sp = sp_ff;
        case (state_ff)
            S_RUN: begin
                if (irq_take) begin
                    // entry only at an instruction boundary
                    if (sp_ff != `MCX_STACK_DEPTH) begin
                        nxt_stk[sp_ff] = prog_addr_ff;
                        nxt_sp = sp_ff + 3'd1;
                    end
                    nxt_pc = irq_vector;
                    nxt_sav_z = zero_ff;
                    nxt_sav_c = carry_ff;
                    nxt_isr = 1'b1;
                end else begin
                    nxt_cyc = last ? 3'd0 : cyc_ff + 3'd1;
                    case (cyc_ff)
                        3'd0: begin
                            nxt_op = prog_data;
                            nxt_ipc = prog_addr_ff;
                            nxt_pc = prog_addr_ff + 12'h001;
                            if (cls_cur == C_IND) nxt_daddr = ptr_ff[{1'b0, prog_data[4]}];
                            if (cls_cur == C_SD) nxt_daddr = `MCX_ADDR_X | {6'h00, prog_data[7:6]}; // RULE_13
                        end
                        3'd1: begin
                            if (cls_cur inside {C_DIR, C_IMM, C_JP, C_CALL, C_BTB, C_BSC})
                                nxt_pc = prog_addr_ff + 12'h001;
                            if (cls_cur inside {C_IMM, C_JP, C_CALL})
                                nxt_opnd = prog_data; // RULE_01 RULE_10
                            else if (cls_cur inside {C_DIR, C_BTB, C_BSC})
                                nxt_daddr = prog_data; // RULE_02 RULE_09
                        end
                        3'd2: begin
                            if (!(cls_cur inside {C_IMM, C_JP, C_CALL})) nxt_opnd = rd_val;
                            if (cls_cur == C_BTB) begin
                                nxt_disp = prog_data;
                                nxt_pc = prog_addr_ff + 12'h001;
                            end
                        end
                        default: ;
                    endcase
                    if (last) begin
                        nxt_done = 1'b1;
                        case (cls_ex)
                            C_REL: if (rel_taken(op_ff, zero_ff, carry_ff)) nxt_pc = short_tgt; // RULE_05 RULE_06
                            C_JP: nxt_pc = {op_ff[7:4], opnd_ff}; // RULE_10
                            C_CALL: begin
                                if (sp_ff != `MCX_STACK_DEPTH) begin
                                    nxt_stk[sp_ff] = prog_addr_ff;
                                    nxt_sp = sp_ff + 3'd1;
                                end
                                nxt_pc = {op_ff[7:4], opnd_ff}; // RULE_10
                            end
                            C_BTB: begin
                                nxt_c = tbit; // RULE_08
                                if (tbit == op_ff[4]) nxt_pc = bt_tgt; // RULE_07
                            end
                            C_INH: begin
                                case (op_ff[7:4])
                                    `MCX_INH_RET, `MCX_INH_INTERRUPT_RETURN_OP: begin
                                        if (sp_ff != 3'd0) begin
                                            nxt_sp = sp_ff - 3'd1;
                                            nxt_pc = stk_ff[sp_ff - 3'd1];
                                        end
                                        if (op_ff[7:4] == `MCX_INH_INTERRUPT_RETURN_OP) begin
                                            nxt_z = sav_z_ff; // RULE_11
                                            nxt_c = sav_c_ff;
                                            nxt_isr = 1'b0;
                                        end
                                    end
                                    // watchdog turns stop into wait
                                    `MCX_INH_STOP: nxt_state = watchdog_sel ? S_WAIT : S_STOP; // RULE_12
                                    `MCX_INH_WAIT: nxt_state = S_WAIT;
                                    default: ;
                                endcase
                            end
                            default: ;
                        endcase
                        if (alu_wr) begin
                            if (waddr == `MCX_ADDR_ACC) nxt_acc = alu_res; // RULE_01 RULE_03
                            else if (is_ptr(waddr)) nxt_ptr[waddr[1:0]] = alu_res; // RULE_13
                            else begin
                                nxt_we = 1'b1; // RULE_02 RULE_09
                                nxt_wdata = alu_res;
                            end
                        end
                        // clearing memory other than the accumulator leaves flags
                        if (func_ex != F_CLR || waddr == `MCX_ADDR_ACC) begin
                            if (upd_z) nxt_z = alu_z; // RULE_01 RULE_03 RULE_04
                            if (upd_c) nxt_c = alu_c;
                        end
                    end
                end
            end
            S_WAIT, S_STOP: begin
                if (wake || irq_req) nxt_state = S_RUN;
            end
            default: nxt_state = S_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= S_RUN;
            cyc_ff <= 3'd0;
            op_ff <= 8'h00;
            ipc_ff <= `MCX_PC_RST;
            opnd_ff <= 8'h00;
            disp_ff <= 8'h00;
            prog_addr_ff <= `MCX_PC_RST;
            dmem_addr_ff <= 8'h00;
            dmem_we_ff <= 1'b0;
            dmem_wdata_ff <= 8'h00;
            acc_ff <= 8'h00;
            zero_ff <= 1'b0;
            carry_ff <= 1'b0;
            in_isr_ff <= 1'b0;
            sav_z_ff <= 1'b0;
            sav_c_ff <= 1'b0;
            wait_ff <= 1'b0;
            stop_ff <= 1'b0;
            done_ff <= 1'b0;
            ptr_ff <= '{default: 8'h00};
            stk_ff <= '{default: 12'h000};
            sp_ff <= 3'd0;
        end else begin
            state_ff <= nxt_state;
            cyc_ff <= nxt_cyc;
            op_ff <= nxt_op;
            ipc_ff <= nxt_ipc;
            opnd_ff <= nxt_opnd;
            disp_ff <= nxt_disp;
            prog_addr_ff <= nxt_pc;
            dmem_addr_ff <= nxt_daddr;
            dmem_we_ff <= nxt_we;
            dmem_wdata_ff <= nxt_wdata;
            acc_ff <= nxt_acc;
            zero_ff <= nxt_z;
            carry_ff <= nxt_c;
            in_isr_ff <= nxt_isr;
            sav_z_ff <= nxt_sav_z;
            sav_c_ff <= nxt_sav_c;
            wait_ff <= (nxt_state == S_WAIT);
            stop_ff <= (nxt_state == S_STOP);
            done_ff <= nxt_done;
            ptr_ff <= nxt_ptr;
            stk_ff <= nxt_stk;
            sp_ff <= nxt_sp;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_alu_len; // RULE_01
        start && (func_of(prog_data) inside {F_ADD, F_AND, F_CP, F_SUB}) |-> ##4 done_ff;
    endproperty
    a_alu_len: assert property (p_alu_len) else $error("alu op not done in 4 cycles");
    property p_clr_any; // RULE_02
        start && cls_cur == C_DIR && func_of(prog_data) == F_CLR ##1
            (prog_data != `MCX_ADDR_ACC && !is_ptr(prog_data)) |-> ##3 dmem_we_ff && dmem_wdata_ff == 8'h00;
    endproperty
    a_clr_any: assert property (p_clr_any) else $error("clear of data byte not written");
    property p_com_acc; // RULE_03
        start && func_of(prog_data) == F_COM |-> ##2 acc_ff == ~$past(acc_ff, 2);
    endproperty
    a_com_acc: assert property (p_com_acc) else $error("complement result wrong");
    property p_incdec_c; // RULE_04
        start && (func_of(prog_data) inside {F_INC, F_DEC}) |=> $stable(carry_ff) [*4];
    endproperty
    a_incdec_c: assert property (p_incdec_c) else $error("inc/dec changed carry");
    property p_rel_flags; // RULE_05
        start && cls_cur == C_REL |=> ($stable(zero_ff) && $stable(carry_ff)) [*2] ##0 done_ff;
    endproperty
    a_rel_flags: assert property (p_rel_flags) else $error("short branch timing or flags wrong");
    property p_rel_tgt; // RULE_06
        start && cls_cur == C_REL && rel_taken(prog_data, zero_ff, carry_ff) |-> ##2
            prog_addr_ff == ($past(prog_data[3], 2) ?
                $past(prog_addr_ff, 2) - {8'h00, $past(prog_data[7:4], 2)} :
                $past(prog_addr_ff, 2) + {8'h00, $past(prog_data[7:4], 2)} + 12'h001);
    endproperty
    a_rel_tgt: assert property (p_rel_tgt) else $error("short branch target wrong");
    property p_btb_len; // RULE_07
        start && cls_cur == C_BTB |-> ##5 done_ff;
    endproperty
    a_btb_len: assert property (p_btb_len) else $error("bit test not done in 5 cycles");
    property p_btb_c; // RULE_08
        done_ff && cls_ex == C_BTB |-> carry_ff == tbit && zero_ff == $past(zero_ff, 5);
    endproperty
    a_btb_c: assert property (p_btb_c) else $error("bit test flags wrong");
    property p_bsc_flags; // RULE_09
        start && cls_cur == C_BSC |=> ($stable(zero_ff) && $stable(carry_ff)) [*4];
    endproperty
    a_bsc_flags: assert property (p_bsc_flags) else $error("bit set/clear touched flags");
    property p_jump; // RULE_10
        start && (cls_cur inside {C_JP, C_CALL}) |-> ##4
            prog_addr_ff == {$past(prog_data[7:4], 4), $past(prog_data, 3)};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_ctl; // RULE_11
        start && cls_cur == C_INH && prog_data[7:4] inside {`MCX_INH_NOP, `MCX_INH_RET, `MCX_INH_WAIT}
            |=> ($stable(zero_ff) && $stable(carry_ff)) [*2] ##0 done_ff;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control op timing or flags wrong");
    property p_stop_wdg; // RULE_12
        start && cls_cur == C_INH && prog_data[7:4] == `MCX_INH_STOP ##1 watchdog_sel
            |=> wait_ff && !stop_ff;
    endproperty
    a_stop_wdg: assert property (p_stop_wdg) else $error("stop not replaced by wait");
    property p_ptr_int; // RULE_13
        dmem_we_ff |-> !is_ptr(dmem_addr_ff) && dmem_addr_ff != `MCX_ADDR_ACC;
    endproperty
    a_ptr_int: assert property (p_ptr_int) else $error("core register written outside");

    c_rel_taken: cover property (start && cls_cur == C_REL && rel_taken(prog_data, zero_ff, carry_ff));
    c_btb_done: cover property (done_ff && cls_ex == C_BTB && tbit == op_ff[4]);
    c_call: cover property (start && cls_cur == C_CALL ##4 done_ff);
    c_irq: cover property (irq_take);
endmodule : mcx_core

// ---- mcx_core_tb.sv ----
// Purpose: self-checking bench for the mcx core
// Assumes: program and data memory modelled here, answering in the same cycle
// Notes: one interrupt entry at a fixed vector; complement, rotate and shift ops check flags, not length
`timescale 1ns/100ps
module mcx_core_tb;
    logic clk, rst_n, wake, watchdog_sel, irq_req;
    logic [11:0] prog_addr_ff;
    logic [7:0] dmem_addr_ff, dmem_wdata_ff, acc_ff;
    logic dmem_we_ff, zero_ff, carry_ff, in_isr_ff, wait_ff, stop_ff, done_ff;
    logic [7:0] rom [4096];
    logic [7:0] ram [256];
    int err_total = 0;
    int cmp_count = 0;
    mcx_core i_dut (.clk(clk), .rst_n(rst_n), .prog_addr_ff(prog_addr_ff),
        .prog_data(rom[prog_addr_ff]), .dmem_addr_ff(dmem_addr_ff), .dmem_we_ff(dmem_we_ff),
        .dmem_wdata_ff(dmem_wdata_ff), .dmem_rdata(ram[dmem_addr_ff]), .irq_req(irq_req),
        .irq_vector(12'h200), .wake(wake), .watchdog_sel(watchdog_sel), .zero_ff(zero_ff),
        .carry_ff(carry_ff), .acc_ff(acc_ff), .in_isr_ff(in_isr_ff), .wait_ff(wait_ff),
        .stop_ff(stop_ff), .done_ff(done_ff));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (dmem_we_ff) ram[dmem_addr_ff] <= dmem_wdata_ff;
    task chk(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task complete_run;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // returns in cycle 0 of the first instruction
    task boot;
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
    endtask : boot
    task put(input logic [11:0] a, input logic [7:0] b[$]);
        foreach (b[i]) rom[a + i] = b[i];
    endtask : put
    // cyc 0 skips the length check
    task step(input int cyc, input logic [11:0] pc, input logic [9:0] st);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done_ff !== 1'b1 && n < 20);
        if (cyc > 0) chk(n[11:0], cyc[11:0]);
        chk(prog_addr_ff, pc);
        chk({2'b00, acc_ff, zero_ff, carry_ff}, {2'b00, st});
    endtask : step
    task s_alu;
        ram[8'h10] = 8'hfe;
        ram[8'h01] = 8'h05;
        put(12'h000, '{8'h1f, 8'hf0, 8'h1f, 8'h10, 8'h8f, 8'h10, 8'h7f, 8'h01, 8'h5f,
            8'hff, 8'h3f, 8'h0f, 8'h5d, 8'h6d, 8'h7d, 8'haf, 8'h10, 8'hcf, 8'h10, 8'h05, 8'h07});
        boot();
        step(4, 12'h002, {8'hf0, 2'b00});
        step(4, 12'h004, {8'h00, 2'b11});
        step(4, 12'h006, {8'h00, 2'b01});
        step(4, 12'h008, {8'hff, 2'b01});
        chk({4'h0, ram[8'h10]}, 12'h0ff);
        step(4, 12'h00a, {8'hff, 2'b10});
        step(4, 12'h00c, {8'h0f, 2'b00});
        step(0, 12'h00d, {8'hf0, 2'b00});
        step(0, 12'h00e, {8'he0, 2'b01});
        step(0, 12'h00f, {8'hc0, 2'b01});
        step(4, 12'h011, {8'hc0, 2'b01});
        @(negedge clk);
        chk({4'h0, ram[8'h10]}, 12'h0fe);
        // one negedge already spent, so no length check here
        step(0, 12'h013, {8'hc0, 2'b01});
        step(4, 12'h014, {8'hc0, 2'b01});
        step(4, 12'h015, {8'hc5, 2'b00});
        chk({4'h0, ram[8'h10]}, 12'h000);
    endtask : s_alu
    task s_flow;
        ram[8'h20] = 8'h04;
        put(12'h000, '{8'h40, 8'h0d, 8'ha9, 8'h55, 8'h0d, 8'h06, 8'h4a});
        put(12'ha55, '{8'h53, 8'h20, 8'h80});
        put(12'h9d7, '{8'hf6, 8'h4b, 8'h20, 8'h11, 8'h00, 8'h23, 8'h20, 8'h02});
        put(12'h9e7, '{8'hfe});
        put(12'h100, '{8'h1d});
        boot();
        step(2, 12'h005, 10'h000);
        step(2, 12'h006, 10'h000);
        step(2, 12'h002, 10'h000);
        step(4, 12'ha55, 10'h000);
        step(5, 12'h9d7, 10'h001);
        step(2, 12'h9e7, 10'h001);
        step(2, 12'h9d8, 10'h001);
        step(4, 12'h9da, 10'h001);
        step(4, 12'h100, 10'h001);
        step(2, 12'h9dc, 10'h001);
        step(5, 12'h9e0, 10'h000);
        chk({4'h0, ram[8'h20]}, 12'h000);
    endtask : s_flow
    task s_power;
        put(12'h000, '{8'h3d});
        put(12'h200, '{8'h1f, 8'h00, 8'h2d});
        watchdog_sel = 1'b1;
        boot();
        step(2, 12'h001, 10'h000);
        repeat (2) @(negedge clk);
        chk({10'h0, wait_ff, stop_ff}, 12'h002);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        @(negedge clk);
        chk({11'h0, wait_ff}, 12'h000);
        watchdog_sel = 1'b0;
        boot();
        step(2, 12'h001, 10'h000);
        repeat (2) @(negedge clk);
        chk({10'h0, wait_ff, stop_ff}, 12'h001);
        // request wakes the core, entry saves Z=0 C=0
        irq_req = 1'b1;
        step(0, 12'h202, 10'h002);
        chk({11'h0, in_isr_ff}, 12'h001);
        // drop before return so it does not re-enter
        irq_req = 1'b0;
        step(2, 12'h001, 10'h000);
        chk({11'h0, in_isr_ff}, 12'h000);
    endtask : s_power
    initial begin
        rst_n = 1'b0;
        wake = 1'b0;
        irq_req = 1'b0;
        watchdog_sel = 1'b0;
        foreach (rom[i]) rom[i] = 8'h0d;
        foreach (ram[i]) ram[i] = 8'h00;
        s_alu();
        s_flow();
        s_power();
        complete_run();
    end
    // all scenarios need well under 200 cycles
    initial begin
        #(25 * 3000);
        err_total++;
        complete_run();
    end
endmodule : mcx_core_tb
